// *** cdd_pkg.sv ***
// Constants and carrier types of the character display command decoder.
// Assumes a single 250 MHz core clock; all timing figures derive from it.
package cdd_pkg;
    // =====================================================================
    // Timing.
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLR_TIME_US   = 1530;
    localparam int SET_TIME_US   = 39000;
    localparam int DATA_TIME_US  = 43000;
    localparam int CLR_CYC  = (CLR_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int SET_CYC  = (SET_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int DATA_CYC = (DATA_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int CNT_W    = 24;

    // =====================================================================
    // Memory sizes and fill value.
    localparam int AP_W        = 7;
    localparam int TEXT_DEPTH  = 128;
    localparam int GLYPH_DEPTH = 64;
    localparam logic [7:0] SPACE_CODE = 8'h20;

    // =====================================================================
    // Field positions inside instruction and status bytes.
    localparam int ENT_DIR  = 1;
    localparam int ENT_SCR  = 0;
    localparam int DSP_VIS  = 2;
    localparam int DSP_SHW  = 1;
    localparam int DSP_FLS  = 0;
    localparam int SH_TGT   = 3;
    localparam int SH_DIR   = 2;
    localparam int FN_BW    = 4;
    localparam int FN_ROW   = 3;
    localparam int FN_TALL  = 2;
    localparam int FLAG_BIT = 7;

    // =====================================================================
    // Carrier types.
    typedef struct packed {
        logic       rs;
        logic       rw;
        logic       st;
        logic [7:0] data;
    } cdd_pins_t;

    typedef struct packed {
        logic panel_visible;
        logic pointer_shown;
        logic pointer_flash;
        logic step_direction;
        logic auto_scroll;
        logic bus_width_sel;
        logic two_row;
        logic tall_glyph;
    } cdd_mode_t;

    localparam cdd_mode_t MODE_RST = '{1'b0, 1'b0, 1'b0, 1'b1,
                                       1'b0, 1'b1, 1'b0, 1'b0};
endpackage

// *** cdd_decoder.sv ***
// Host port and instruction decoder of a character display controller.
// Assumes the host pins arrive asynchronously and are resynchronised here.
// Operation
// R1 - Select high carries RAM data; low carries instructions or status.
// R2 - Read high makes the device drive data lines; low, host drives.
// R3 - Host keeps strobe phases at least 230 ns, cycles 500 ns.
// R4 - Clear fills text RAM with spaces and zeroes the pointer.
// R5 - Return home zeroes pointer and display shift; text RAM untouched.
// R6 - Entry mode stores step direction and auto scroll enable.
// R7 - Display control latches visible, pointer shown and flash bits.
// R8 - Shift instruction moves pointer or display, RAM unchanged.
// R9 - Function set selects bus width, row count and glyph height.
// R10 - Glyph address set loads pointer; data then targets glyph RAM.
// R11 - Text address set loads pointer; data then targets text RAM.
// R12 - Status read returns busy flag on bit 7, pointer below.
// R13 - Data write stores byte into the last selected RAM.
// R14 - Data read returns byte at the pointer from selected RAM.
// R15 - Shift codes: 00 left, 01 right pointer; 1x shifts display.
// R16 - Narrow bus moves each byte as two nibbles, high first.
// R17 - Host polls busy flag low before the next instruction.
// R18 - After each data write the pointer steps by entry direction.
// R19 - Instructions decode by their most significant set bit.
// R20 - Writes taken on strobe fall; read data driven while strobe high.
`timescale 1ns/100ps
`default_nettype none
module cdd_decoder #(
    parameter int CLR_CYC  = cdd_pkg::CLR_CYC,
    parameter int SET_CYC  = cdd_pkg::SET_CYC,
    parameter int DATA_CYC = cdd_pkg::DATA_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire cdd_pkg::cdd_pins_t pins,
    output var  logic [7:0]        data_lines_out,
    output var  logic              data_lines_oe,
    output var  cdd_pkg::cdd_mode_t mode,
    output var  logic [6:0]        address_pointer,
    output var  logic [6:0]        display_shift,
    output var  logic              glyph_sel,
    output var  logic              internal_op_flag
);
    localparam int CW = cdd_pkg::CNT_W;
    localparam int TD = cdd_pkg::TEXT_DEPTH;
    localparam int GD = cdd_pkg::GLYPH_DEPTH;

    // =====================================================================
    // Pin synchroniser and strobe edges.
    cdd_pkg::cdd_pins_t s1_q;
    cdd_pkg::cdd_pins_t s2_q;
    logic               st3_q;

    // Two flops per pin; edges compare the second and third stages only.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            st3_q <= 1'b0;
        end else begin
            s1_q  <= pins;
            s2_q  <= s1_q;
            st3_q <= s2_q.st;
        end
    end

    logic st_fall;
    logic st_rise;
    assign st_fall = st3_q && !s2_q.st; // see R20
    assign st_rise = s2_q.st && !st3_q; // see R20

    // =====================================================================
    // State.
    cdd_pkg::cdd_mode_t mode_q, mode_d;
    logic [6:0]   ap_q, ap_d;
    logic [6:0]   shift_q, shift_d;
    logic         glyph_q, glyph_d;
    logic         busy_q, busy_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic         clr_q, clr_d;
    logic [6:0]   clr_idx_q, clr_idx_d;
    logic         half_q, half_d;
    logic [3:0]   nib_q, nib_d;
    logic [7:0]   hold_q, hold_d;
    logic [7:0]   dout_q, dout_d;
    logic         oe_q, oe_d;
    logic [7:0]   text_ram [TD];
    logic [7:0]   glyph_ram [GD];
    logic         ram_we;
    logic         ram_glyph;
    logic [6:0]   ram_wa;
    logic [7:0]   ram_wd;
    logic         full;
    logic [7:0]   wr_byte;
    logic [7:0]   rd_data;
    logic [7:0]   src;
    logic [6:0]   ap_step;
    logic         cmd_go;
    logic         dwr_go;
    logic         drd_go;

    // A byte completes on this fall in wide mode, or on the second nibble.
    assign full    = mode_q.bus_width_sel || half_q; // see R16
    assign wr_byte = mode_q.bus_width_sel ? s2_q.data
                     : {nib_q, s2_q.data[7:4]}; // see R16
    assign rd_data = glyph_q ? glyph_ram[ap_q[5:0]] : text_ram[ap_q];
    assign cmd_go  = st_fall && full && !s2_q.rw && !s2_q.rs
                     && !busy_q; // see R1
    assign dwr_go  = st_fall && full && !s2_q.rw && s2_q.rs && !busy_q;
    assign drd_go  = st_fall && full && s2_q.rw && s2_q.rs && !busy_q;

    // Pointer step; glyph addressing wraps inside its six bits.
    always_comb begin
        ap_step = mode_q.step_direction ? ap_q + 7'h01
                  : ap_q - 7'h01; // see R18
        ap_step[6] = ap_step[6] && !glyph_q;
    end

    // =====================================================================
    // Next state: transfers, decode, clear sweep and busy timer.
    always_comb begin
        mode_d    = mode_q;
        ap_d      = ap_q;
        shift_d   = shift_q;
        glyph_d   = glyph_q;
        cnt_d     = cnt_q;
        clr_d     = clr_q;
        clr_idx_d = clr_idx_q;
        half_d    = half_q;
        nib_d     = nib_q;
        hold_d    = hold_q;
        dout_d    = dout_q;
        oe_d      = oe_q;
        ram_we    = 1'b0;
        ram_glyph = glyph_q;
        ram_wa    = ap_q;
        ram_wd    = s2_q.data;
        src       = s2_q.rs ? rd_data : {busy_q, ap_q}; // see R12

        if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end

        // The clear sweep writes one space per cycle while busy stands.
        if (clr_q) begin
            ram_we    = 1'b1; // see R4
            ram_glyph = 1'b0;
            ram_wa    = clr_idx_q;
            ram_wd    = cdd_pkg::SPACE_CODE;
            clr_idx_d = clr_idx_q + 7'h01;
            if (clr_idx_q == 7'(TD - 1)) begin
                clr_d = 1'b0;
            end
        end

        // Read data is latched at the rise and held until the fall.
        if (st_rise && s2_q.rw) begin
            oe_d = 1'b1; // see R2
            if (mode_q.bus_width_sel) begin
                dout_d = src;
                hold_d = src;
            end else if (!half_q) begin
                dout_d = {src[7:4], 4'h0}; // see R16
                hold_d = src;
            end else begin
                dout_d = {hold_q[3:0], 4'h0};
            end
        end

        if (st_fall) begin
            oe_d = 1'b0; // see R20
            if (!mode_q.bus_width_sel) begin
                half_d = !half_q;
                nib_d  = s2_q.data[7:4];
            end
        end

        // Leading one selects the instruction.
        if (cmd_go) begin
            cnt_d = CW'(SET_CYC);
            if (wr_byte[7]) begin // see R19
                ap_d    = wr_byte[6:0]; // see R11
                glyph_d = 1'b0;
            end else if (wr_byte[6]) begin
                ap_d    = {1'b0, wr_byte[5:0]}; // see R10
                glyph_d = 1'b1;
            end else if (wr_byte[5]) begin
                mode_d.bus_width_sel = wr_byte[cdd_pkg::FN_BW]; // see R9
                mode_d.two_row       = wr_byte[cdd_pkg::FN_ROW];
                mode_d.tall_glyph    = wr_byte[cdd_pkg::FN_TALL];
                half_d               = 1'b0;
            end else if (wr_byte[4]) begin
                if (wr_byte[cdd_pkg::SH_TGT]) begin
                    shift_d = wr_byte[cdd_pkg::SH_DIR] ? shift_q - 7'h01
                              : shift_q + 7'h01; // see R15
                end else begin
                    ap_d = wr_byte[cdd_pkg::SH_DIR] ? ap_q + 7'h01
                           : ap_q - 7'h01; // see R8
                end
            end else if (wr_byte[3]) begin
                mode_d.panel_visible = wr_byte[cdd_pkg::DSP_VIS]; // see R7
                mode_d.pointer_shown = wr_byte[cdd_pkg::DSP_SHW];
                mode_d.pointer_flash = wr_byte[cdd_pkg::DSP_FLS];
            end else if (wr_byte[2]) begin
                mode_d.step_direction = wr_byte[cdd_pkg::ENT_DIR]; // see R6
                mode_d.auto_scroll    = wr_byte[cdd_pkg::ENT_SCR];
            end else if (wr_byte[1]) begin
                ap_d    = '0; // see R5
                shift_d = '0;
                glyph_d = 1'b0;
                cnt_d   = CW'(CLR_CYC);
            end else if (wr_byte[0]) begin
                ap_d      = '0; // see R4
                shift_d   = '0;
                glyph_d   = 1'b0;
                clr_d     = 1'b1;
                clr_idx_d = '0;
                mode_d.step_direction = 1'b1;
                cnt_d     = CW'(CLR_CYC);
            end
        end

        // Data write into the selected RAM, then step and maybe scroll.
        if (dwr_go) begin
            ram_we = 1'b1; // see R13
            ram_wd = wr_byte;
            ap_d   = ap_step; // see R18
            cnt_d  = CW'(DATA_CYC);
            if (mode_q.auto_scroll && !glyph_q) begin
                shift_d = mode_q.step_direction ? shift_q + 7'h01
                          : shift_q - 7'h01;
            end
        end

        // A data read advances the pointer once its byte is complete.
        if (drd_go) begin
            ap_d  = ap_step; // see R14
            cnt_d = CW'(DATA_CYC);
        end

        busy_d = (cnt_d != '0) || clr_d;
    end

    // =====================================================================
    // Registers.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q    <= cdd_pkg::MODE_RST;
            ap_q      <= '0;
            shift_q   <= '0;
            glyph_q   <= 1'b0;
            busy_q    <= 1'b0;
            cnt_q     <= '0;
            clr_q     <= 1'b0;
            clr_idx_q <= '0;
            half_q    <= 1'b0;
            nib_q     <= '0;
            hold_q    <= '0;
            dout_q    <= '0;
            oe_q      <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            ap_q      <= ap_d;
            shift_q   <= shift_d;
            glyph_q   <= glyph_d;
            busy_q    <= busy_d;
            cnt_q     <= cnt_d;
            clr_q     <= clr_d;
            clr_idx_q <= clr_idx_d;
            half_q    <= half_d;
            nib_q     <= nib_d;
            hold_q    <= hold_d;
            dout_q    <= dout_d;
            oe_q      <= oe_d;
        end
    end

    // RAM contents carry no reset; software clears text RAM by instruction, glyph RAM never.
    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            if (ram_glyph) begin
                glyph_ram[ram_wa[5:0]] <= ram_wd;
            end else begin
                text_ram[ram_wa] <= ram_wd;
            end
        end
    end

    assign data_lines_out   = dout_q;
    assign data_lines_oe    = oe_q;
    assign mode             = mode_q;
    assign address_pointer  = ap_q;
    assign display_shift    = shift_q;
    assign glyph_sel        = glyph_q;
    assign internal_op_flag = busy_q; // see R17

    // =====================================================================
    // Assertions.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    clear_cmd_a: assert property ( // see R4
        cmd_go && wr_byte == 8'h01 |=> ap_q == '0 && clr_q && busy_q
        ##1 ram_we && ram_wd == cdd_pkg::SPACE_CODE)
        else $error("clear did not start the sweep");
    home_cmd_a: assert property ( // see R5
        cmd_go && wr_byte[7:1] == 7'h01 |=> ap_q == '0 && shift_q == '0)
        else $error("return home left pointer or shift");
    entry_mode_a: assert property ( // see R6
        cmd_go && wr_byte[7:2] == 6'h01
        |=> mode_q.step_direction == $past(wr_byte[1])
            && mode_q.auto_scroll == $past(wr_byte[0]))
        else $error("entry mode not stored");
    disp_ctrl_a: assert property ( // see R7
        cmd_go && wr_byte[7:3] == 5'h01
        |=> mode_q.panel_visible == $past(wr_byte[2])
            && mode_q.pointer_flash == $past(wr_byte[0]))
        else $error("display control not stored");
    func_set_a: assert property ( // see R9
        cmd_go && wr_byte[7:5] == 3'h1
        |=> mode_q.bus_width_sel == $past(wr_byte[4]) && !half_q)
        else $error("function set not stored");
    glyph_addr_a: assert property ( // see R10
        cmd_go && wr_byte[7:6] == 2'h1
        |=> glyph_q && ap_q == {1'b0, $past(wr_byte[5:0])})
        else $error("glyph address not loaded");
    text_addr_a: assert property ( // see R11
        cmd_go && wr_byte[7] |=> !glyph_q && ap_q == $past(wr_byte[6:0]))
        else $error("text address not loaded");
    status_read_a: assert property ( // see R12
        st_rise && s2_q.rw && !s2_q.rs && mode_q.bus_width_sel
        |=> oe_q && dout_q == {$past(busy_q), $past(ap_q)})
        else $error("status word wrong");
    write_step_a: assert property ( // see R18
        dwr_go && !glyph_q && mode_q.step_direction
        |=> ap_q == $past(ap_q) + 7'h01 && busy_q)
        else $error("pointer did not step after write");
    drive_oe_a: assert property ( // see R20
        $rose(oe_q) |-> $past(st_rise) && $past(s2_q.rw))
        else $error("data lines driven outside a read");
endmodule
`default_nettype wire

// *** cdd_host.sv ***
// Host processor model that drives the strobed parallel port of the decoder.
// Assumes the bench calls its tasks and that core_clk paces every phase.
`timescale 1ns/100ps
`default_nettype none
module cdd_host (
    input  wire logic               core_clk,
    output var  cdd_pkg::cdd_pins_t pins,
    input  wire logic [7:0]         data_lines_out,
    input  wire logic               data_lines_oe
);
    // =====================================================================
    // Strobed transfers.
    localparam int PHASE = 63;
    logic narrow = 1'b0;
    initial pins = '0;

    // One strobe: 63 cycles high gives 252 ns; low lasts 64 cycles to the next, 508 ns cycles.
    task automatic strobe(input logic rs, input logic rw,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        #1;
        pins.rs = rs;
        pins.rw = rw;
        pins.data = rw ? ~pins.data : d;
        pins.st = 1'b1;
        repeat (PHASE) @(posedge core_clk);
        #1;
        q = (data_lines_oe === 1'b1) ? data_lines_out : 'x;
        pins.st = 1'b0;
        repeat (PHASE) @(posedge core_clk);
        #1;
        // A released bus must not keep showing the old value.
        pins.data = ~pins.data;
    endtask

    // A whole byte, split high nibble first on the narrow bus.
    task automatic xfer(input logic rs, input logic rw,
                        input logic [7:0] d, output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (narrow) begin
            strobe(rs, rw, {d[7:4], ~d[3:0]}, hi);
            strobe(rs, rw, {d[3:0], ~d[7:4]}, lo);
            q = {hi[7:4], lo[7:4]};
        end else begin
            strobe(rs, rw, d, q);
        end
    endtask

    // Polls the status word until busy reads low, at most 40 times.
    task automatic wait_idle(output logic ok);
        logic [7:0] q;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            xfer(1'b0, 1'b1, 8'h00, q);
            ok = (q[7] === 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the decoder against a behavioural model.
// Assumes the host model in cdd_host.sv and short execution counts.
`timescale 1ns/100ps
`default_nettype none
module tb;
    // =====================================================================
    // Clock, reset and instances.
    logic               core_clk = 1'b0;
    logic               resetn   = 1'b0;
    cdd_pkg::cdd_pins_t pins;
    logic [7:0]         dout;
    logic               oe;
    cdd_pkg::cdd_mode_t mode;
    logic [6:0]         ap_o;
    logic [6:0]         sh_o;
    logic               gl_o;
    logic               busy;
    int                 mismatches = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    cdd_pkg::cdd_mode_t md = cdd_pkg::MODE_RST;
    logic [6:0]         ap = 7'h00;
    logic [6:0]         sh = 7'h00;
    logic               gl = 1'b0;
    logic [7:0]         txt [128];
    logic [7:0]         gly [64];
    logic [7:0]         q;
    logic               ok;

    initial forever #2 core_clk = ~core_clk;

    // Clear busy must outlast the status read and the refused write after it.
    cdd_decoder #(.CLR_CYC(400), .SET_CYC(8), .DATA_CYC(8)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .pins(pins),
        .data_lines_out(dout), .data_lines_oe(oe), .mode(mode),
        .address_pointer(ap_o), .display_shift(sh_o), .glyph_sel(gl_o),
        .internal_op_flag(busy));
    cdd_host i_host (.core_clk(core_clk), .pins(pins),
        .data_lines_out(dout), .data_lines_oe(oe));

    // =====================================================================
    // Comparison, model and closing tasks.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_rd(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask

    // Compares every state output with the model after an operation.
    task automatic chk_st();
        total_checks++;
        if ({mode, ap_o, sh_o, gl_o, busy} !== {md, ap, sh, gl, 1'b0}) begin
            mismatches++;
            $display("MISMATCH state exp %h got %h", {md, ap, sh, gl, 1'b0},
                     {mode, ap_o, sh_o, gl_o, busy});
        end
    endtask

    // Glyph addresses wrap inside six bits, text ones inside seven.
    function automatic logic [6:0] step(logic [6:0] a, logic up);
        logic [6:0] n;
        n = up ? a + 7'd1 : a - 7'd1;
        return gl ? {1'b0, n[5:0]} : n;
    endfunction

    task automatic idle();
        i_host.wait_idle(ok);
        if (!ok) begin
            mismatches++;
            $display("MISMATCH busy exp 0 got 1");
        end
        chk_st();
    endtask

    // Sends one instruction and keeps the model in step with it.
    task automatic instr(logic [7:0] b);
        i_host.xfer(1'b0, 1'b0, b, q);
        casez (b)
            8'b1???????: {gl, ap} = {1'b0, b[6:0]};
            8'b01??????: {gl, ap} = {1'b1, 1'b0, b[5:0]};
            8'b001?????: {md.bus_width_sel, md.two_row,
                          md.tall_glyph} = b[4:2];
            8'b0001????: if (b[3]) sh = b[2] ? sh - 7'd1 : sh + 7'd1;
                         else ap = step(ap, b[2]);
            8'b00001???: {md.panel_visible, md.pointer_shown,
                          md.pointer_flash} = b[2:0];
            8'b000001??: {md.step_direction, md.auto_scroll} = b[1:0];
            8'b0000001?: {gl, ap, sh} = 15'h0000;
            8'b00000001: begin
                foreach (txt[i]) txt[i] = cdd_pkg::SPACE_CODE;
                {gl, ap, sh, md.step_direction} = 16'h0001;
            end
            default: ;
        endcase
        if (b[7:5] == 3'b001) i_host.narrow = ~b[4];
        idle();
    endtask

    task automatic wdata(logic [7:0] b);
        i_host.xfer(1'b1, 1'b0, b, q);
        if (gl) gly[ap[5:0]] = b;
        else txt[ap] = b;
        if (md.auto_scroll && !gl) begin
            sh = md.step_direction ? sh + 7'd1 : sh - 7'd1;
        end
        ap = step(ap, md.step_direction);
        idle();
    endtask

    task automatic rdata();
        i_host.xfer(1'b1, 1'b1, 8'h00, q);
        chk_rd("ram read", gl ? gly[ap[5:0]] : txt[ap], q);
        ap = step(ap, md.step_direction);
        idle();
    endtask

    // A hang counts against the run and still reaches the verdict.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            conclude();
        end
    end

    // =====================================================================
    // Scenarios.
    initial begin
        logic [7:0] a;
        void'($urandom(32'hf894));
        repeat (6) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        chk_st();
        instr(8'h01);
        i_host.xfer(1'b0, 1'b0, 8'h01, q);
        i_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk_rd("status busy", 8'h80, q);
        i_host.xfer(1'b1, 1'b0, 8'h55, q);
        idle();
        for (int i = 0; i < 4; i++) instr(8'h04 | 8'(i));
        for (int i = 0; i < 8; i++) instr(8'h08 | 8'(i));
        for (int i = 0; i < 4; i++) instr(8'h30 | 8'(i << 2));
        for (int d = 0; d < 2; d++) begin
            instr(8'h06 - 8'(d << 1));
            a = 8'($urandom);
            instr(8'h80 | a);
            repeat (4) wdata(8'($urandom));
            instr(8'h80 | a);
            repeat (4) rdata();
        end
        instr(8'h07);
        instr(8'h80 | 8'h7e);
        repeat (3) wdata(8'($urandom));
        for (int i = 0; i < 4; i++) instr(8'h10 | 8'(i << 2));
        instr(8'h03);
        instr(8'h06);
        instr(8'h48);
        repeat (3) wdata(8'($urandom));
        instr(8'h48);
        repeat (3) rdata();
        instr(8'h20);
        instr(8'h80 | 8'h12);
        wdata(8'($urandom));
        instr(8'h80 | 8'h12);
        rdata();
        instr(8'h30);
        i_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk_rd("status word", {1'b0, ap}, q);
        conclude();
    end
endmodule
`default_nettype wire
